/* File: rtl/far_retry.v */
// Automatic retry controller for motor drive protective faults
//
// Overview of operation
// - A selected major fault triggers automatic alarm reset and restart, no external command.
// - Fault group setting 0 to 5 picks a fixed subset of retryable faults.
// - Retry limit 0, the default, means no automatic retry at all.
// - Limit 1-10 retries silently; 101-110 retries 1-10 times with alarm each time.
// - Retries used up and qualifying fault again: stop, report retry count excess fault.
// - Wait a programmable 0 to 10 s, default 1 s, before each retry.
// - Success counter reads cumulative good restarts; writing zero clears it.
// - Success counts only after four wait intervals without a major fault.
// - Faults recurring inside success window keep only the first fault record.
// - Retry reset keeps protection state such as thermal integrator; power-on clears it.
`timescale 1ns/1ps
`include "far_defs.vh"
module far_retry #(
  parameter NF = 8,
  parameter TICK_CYCLES = `FAR_TICK_CYCLES,
  parameter TICK_W = 20,
  parameter CNT_W = 16
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [NF-1:0] i_fault,
  input wire i_ext_reset,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [31:0] o_rdata,
  output reg o_output_stop,
  output reg o_alarm,
  output reg o_retry_reset,
  output reg o_protect_clear,
  output reg o_retry_count_excess_fault
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_WINDOW = 2'h2;
  localparam ST_LOCKED = 2'h3;

  reg [2:0] retry_fault_group_select;
  reg [6:0] retry_limit_setting;
  reg [6:0] retry_wait_interval;
  reg [CNT_W-1:0] retry_success_counter;
  reg [1:0] state;
  reg [3:0] used;
  reg [9:0] ticks;
  reg [NF-1:0] fault_prev;
  reg [2:0] record;
  reg record_valid;
  reg ext_meta;
  reg ext_sync;
  reg ext_prev;
  reg tick_restart;
  wire tick;

  // Sized copies of the header constants
  localparam [31:0] WAIT_DEF32 = `FAR_WAIT_DEF;
  localparam [31:0] WAIT_MAX32 = `FAR_WAIT_MAX;
  localparam [31:0] MULT32 = `FAR_SUCCESS_MULT;
  localparam [6:0] WAIT_DEF = WAIT_DEF32[6:0];
  localparam [6:0] WAIT_MAX = WAIT_MAX32[6:0];
  localparam [11:0] SUCCESS_MULT = MULT32[11:0];

  // Retry-enable mask of the selected fault group
  function [7:0] group_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: group_mask = `FAR_MASK_G0;
        3'h1: group_mask = `FAR_MASK_G1;
        3'h2: group_mask = `FAR_MASK_G2;
        3'h3: group_mask = `FAR_MASK_G3;
        3'h4: group_mask = `FAR_MASK_G4;
        3'h5: group_mask = `FAR_MASK_G5;
        default: group_mask = 8'h00;
      endcase
    end
  endfunction

  // Allowed retry count from the limit setting
  function [3:0] lim_count;
    input [6:0] v;
    reg [6:0] d;
    begin
      d = v - `FAR_LIM_ALARM_OFS;
      if (v >= `FAR_LIM_PLAIN_LO && v <= `FAR_LIM_PLAIN_HI)
        lim_count = v[3:0];
      else if (v >= `FAR_LIM_ALARM_LO && v <= `FAR_LIM_ALARM_HI)
        lim_count = d[3:0];
      else
        lim_count = 4'h0;
    end
  endfunction

  // Alarm-every-retry mode from the limit setting
  function lim_alarm;
    input [6:0] v;
    begin
      lim_alarm = (v >= `FAR_LIM_ALARM_LO && v <= `FAR_LIM_ALARM_HI);
    end
  endfunction

  // Index of the lowest set fault bit
  function [2:0] first_idx;
    input [7:0] f;
    integer k;
    begin
      first_idx = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (f[k])
          first_idx = k[2:0];
      end
    end
  endfunction

  // Status word layout for the read port
  function [31:0] status_word;
    input [1:0] st;
    input exc;
    input stp;
    input alm;
    input [3:0] u;
    input rv;
    begin
      status_word = 32'h0;
      status_word[`FAR_ST_STATE_LSB+1:`FAR_ST_STATE_LSB] = st;
      status_word[`FAR_ST_EXCESS] = exc;
      status_word[`FAR_ST_STOP] = stp;
      status_word[`FAR_ST_ALARM] = alm;
      status_word[`FAR_ST_USED_LSB+3:`FAR_ST_USED_LSB] = u;
      status_word[`FAR_ST_RECVALID] = rv;
    end
  endfunction

  // Restarted on entry to wait and window so every interval starts whole
  far_tick #(
    .DIV(TICK_CYCLES),
    .W(TICK_W)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_restart(tick_restart),
    .o_tick(tick)
  );

  // Only the low eight fault lines have group masks
  wire [NF-1:0] fault_rise = i_fault & ~fault_prev;
  wire [7:0] fault8 = fault_rise[7:0];
  wire fault_new = |fault8;
  wire qualifies = |(fault8 & group_mask(retry_fault_group_select));
  wire [3:0] allowed = lim_count(retry_limit_setting);
  wire alarm_each = lim_alarm(retry_limit_setting);
  wire ext_edge = ext_sync & ~ext_prev;
  wire [9:0] wait_ticks = {3'h0, retry_wait_interval};
  wire [11:0] win_full = {5'h00, retry_wait_interval} * SUCCESS_MULT;
  wire [9:0] win_ticks = win_full[9:0];
  wire wr_ok = i_write && i_wdata[31:7] == 25'h0;

  // Register-bus decode
  wire wr_group = wr_ok && i_addr == `FAR_ADDR_GROUP;
  wire wr_limit = wr_ok && i_addr == `FAR_ADDR_LIMIT;
  wire wr_wait = wr_ok && i_addr == `FAR_ADDR_WAIT;
  wire clr_success = wr_ok && i_addr == `FAR_ADDR_SUCCESS &&
    i_wdata == 32'h0;

  // External reset pin passes two flip-flops
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= i_ext_reset;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Register writes
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      retry_fault_group_select <= `FAR_GROUP_RST;
      retry_limit_setting <= `FAR_LIMIT_RST;
      retry_wait_interval <= WAIT_DEF;
    end else begin
      // Group values above 5 in bits 2:0, or wait values above the maximum, leave the old setting
      if (wr_group && i_wdata[2:0] <= `FAR_GROUP_MAX)
        retry_fault_group_select <= i_wdata[2:0];
      if (wr_limit)
        retry_limit_setting <= i_wdata[6:0];
      if (wr_wait && i_wdata[6:0] <= WAIT_MAX)
        retry_wait_interval <= i_wdata[6:0];
    end
  end

  // Main retry sequencer
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= ST_RUN;
      used <= 4'h0;
      ticks <= 10'h000;
      fault_prev <= {NF{1'b0}};
      record <= 3'h0;
      record_valid <= 1'b0;
      retry_success_counter <= {CNT_W{1'b0}};
      tick_restart <= 1'b0;
      o_output_stop <= 1'b0;
      o_alarm <= 1'b0;
      o_retry_reset <= 1'b0;
      o_protect_clear <= 1'b1;
      o_retry_count_excess_fault <= 1'b0;
    end else begin
      fault_prev <= i_fault;
      tick_restart <= 1'b0;
      o_retry_reset <= 1'b0;
      o_protect_clear <= 1'b0;
      if (tick && state != ST_RUN && state != ST_LOCKED)
        ticks <= ticks + 10'h001;
      // Software clear; a success in the same cycle wins, old count plus one, and the clear is lost
      if (clr_success)
        retry_success_counter <= {CNT_W{1'b0}};
      case (state)
        ST_RUN, ST_WINDOW: begin
          if (fault_new) begin
            o_output_stop <= 1'b1;
            if (!record_valid) begin
              record <= first_idx(fault8);
              record_valid <= 1'b1;
            end
            if (qualifies && allowed != 4'h0 && used < allowed) begin
              state <= ST_WAIT;
              used <= used + 4'h1;
              ticks <= 10'h000;
              tick_restart <= 1'b1;
              o_alarm <= alarm_each;
            end else if (qualifies && allowed != 4'h0) begin
              state <= ST_LOCKED;
              o_retry_count_excess_fault <= 1'b1;
              o_alarm <= 1'b1;
            end else begin
              state <= ST_LOCKED;
              o_alarm <= 1'b1;
            end
          end else if (state == ST_WINDOW && ticks >= win_ticks) begin
            state <= ST_RUN;
            used <= 4'h0;
            record_valid <= 1'b0;
            retry_success_counter <= retry_success_counter +
              {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_WAIT: begin
          if (ticks >= wait_ticks) begin
            // Soft reset of the drive; thermal state is left alone
            o_retry_reset <= 1'b1;
            o_output_stop <= 1'b0;
            o_alarm <= 1'b0;
            state <= ST_WINDOW;
            ticks <= 10'h000;
            tick_restart <= 1'b1;
          end
        end
        // Only an edge on the external reset pin leaves the lock
        ST_LOCKED: begin
          if (ext_edge) begin
            state <= ST_RUN;
            used <= 4'h0;
            record_valid <= 1'b0;
            o_output_stop <= 1'b0;
            o_alarm <= 1'b0;
            o_retry_count_excess_fault <= 1'b0;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Register reads, data valid one cycle after the strobe
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (i_read) begin
      case (i_addr)
        `FAR_ADDR_GROUP: o_rdata <= {29'h0, retry_fault_group_select};
        `FAR_ADDR_LIMIT: o_rdata <= {25'h0, retry_limit_setting};
        `FAR_ADDR_WAIT: o_rdata <= {25'h0, retry_wait_interval};
        `FAR_ADDR_SUCCESS:
          o_rdata <= {{(32-CNT_W){1'b0}}, retry_success_counter};
        `FAR_ADDR_STATUS:
          o_rdata <= status_word(state, o_retry_count_excess_fault,
            o_output_stop, o_alarm, used, record_valid);
        `FAR_ADDR_RECORD: o_rdata <= {29'h0, record};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end
endmodule

/* File: rtl/far_defs.vh */
// Constants for the fault auto-retry controller
`ifndef FAR_DEFS_VH
`define FAR_DEFS_VH

// Clock rate and timer base
`define FAR_CLK_HZ 10000000
`define FAR_TICK_MS 100
`define FAR_TICK_CYCLES (`FAR_CLK_HZ / 1000 * `FAR_TICK_MS)
`define FAR_TICKS_PER_S (1000 / `FAR_TICK_MS)

// Wait interval, seconds
`define FAR_WAIT_DEF_S 1
`define FAR_WAIT_MAX_S 10
`define FAR_WAIT_DEF (`FAR_WAIT_DEF_S * `FAR_TICKS_PER_S)
`define FAR_WAIT_MAX (`FAR_WAIT_MAX_S * `FAR_TICKS_PER_S)
`define FAR_SUCCESS_MULT 4

// Register byte addresses
`define FAR_ADDR_GROUP 8'h00
`define FAR_ADDR_LIMIT 8'h04
`define FAR_ADDR_WAIT 8'h08
`define FAR_ADDR_SUCCESS 8'h0C
`define FAR_ADDR_STATUS 8'h10
`define FAR_ADDR_RECORD 8'h14

// Reset values
`define FAR_GROUP_RST 3'h0
`define FAR_LIMIT_RST 7'h00

// Retry limit encodings
`define FAR_LIM_PLAIN_LO 7'h01
`define FAR_LIM_PLAIN_HI 7'h0A
`define FAR_LIM_ALARM_LO 7'h65
`define FAR_LIM_ALARM_HI 7'h6E
`define FAR_LIM_ALARM_OFS 7'h64
`define FAR_GROUP_MAX 3'h5

// Fault vector bit positions
`define FAR_F_ACCEL_OC 0
`define FAR_F_STEADY_OC 1
`define FAR_F_DECEL_OC 2
`define FAR_F_ACCEL_OV 3
`define FAR_F_STEADY_OV 4
`define FAR_F_DECEL_OV 5
`define FAR_F_MOTOR_THM 6
`define FAR_F_OTHER 7

// Retry-enable masks per fault group
`define FAR_MASK_G0 8'hD9
`define FAR_MASK_G1 8'h07
`define FAR_MASK_G2 8'h10
`define FAR_MASK_G3 8'h10
`define FAR_MASK_G4 8'hB7
`define FAR_MASK_G5 8'h04

// Status field positions
`define FAR_ST_STATE_LSB 0
`define FAR_ST_EXCESS 4
`define FAR_ST_STOP 5
`define FAR_ST_ALARM 6
`define FAR_ST_USED_LSB 8
`define FAR_ST_RECVALID 12

`endif

/* File: rtl/far_tick.v */
// Timer base divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module far_tick #(
  parameter DIV = 1000000,
  parameter W = 20
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_restart,
  output reg o_tick
);
  reg [W-1:0] count;

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      count <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (i_restart) begin
      count <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (count == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
      count <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: sim/far_retry_properties.sv */
// Concurrent checks on the retry controller ports
`timescale 1ns/1ps
module far_props (
  input wire i_clock,
  input wire i_rst_n,
  input wire [7:0] i_fault,
  input wire i_ext_reset,
  input wire i_read,
  input wire [31:0] o_rdata,
  input wire o_output_stop,
  input wire o_alarm,
  input wire o_retry_reset,
  input wire o_protect_clear,
  input wire o_retry_count_excess_fault
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_pulse;
    o_retry_reset ##1 !o_retry_reset;
  endsequence
  sequence s_new_fault;
    |(i_fault & ~$past(i_fault)) && !o_output_stop;
  endsequence
  property p_pulse; o_retry_reset |-> s_pulse; endproperty
  property p_clear; o_retry_reset |-> !o_output_stop && !o_alarm; endproperty
  property p_waited; o_retry_reset |-> $past(o_output_stop); endproperty
  property p_stop; s_new_fault |=> o_output_stop; endproperty
  property p_exc;
    o_retry_count_excess_fault |-> o_output_stop && o_alarm;
  endproperty
  property p_exc_hold;
    $fell(o_retry_count_excess_fault) |-> $past(i_ext_reset, 3);
  endproperty
  property p_pclr; $past(i_rst_n) |-> !o_protect_clear; endproperty
  property p_rdata; !i_read |=> o_rdata == 32'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("long retry");
  a_clear: assert property (p_clear) else $error("retry kept stop");
  a_waited: assert property (p_waited) else $error("no stop");
  a_stop: assert property (p_stop) else $error("fault ignored");
  a_exc: assert property (p_exc) else $error("excess not stopped");
  a_exc_hold: assert property (p_exc_hold) else $error("excess lost");
  a_pclr: assert property (p_pclr) else $error("protect cleared");
  a_rdata: assert property (p_rdata) else $error("rdata not idle");
endmodule

bind far_retry far_props u_far_props (.i_clock, .i_rst_n, .i_fault,
  .i_ext_reset, .i_read, .o_rdata, .o_output_stop, .o_alarm,
  .o_retry_reset, .o_protect_clear, .o_retry_count_excess_fault);

/* File: sim/test_fault_auto_retry.sv */
// Self-checking bench for the fault auto-retry controller
`timescale 1ns/1ps
`include "far_defs.vh"
module test_fault_auto_retry;
  reg clk = 0;
  reg rst_n = 0;
  reg ext = 0;
  reg wr = 0;
  reg rd = 0;
  reg [7:0] fault = 8'h00;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [2:0] g;
  reg [2:0] b;
  wire [31:0] rdata;
  wire stop, alarm, rr, pclr, exc;
  integer err_total = 0;
  integer comparisons = 0;
  integer seed = 8749;
  integer i, n, cnt;
  far_retry #(.TICK_CYCLES(4)) u_far_retry (.i_clock(clk), .i_rst_n(rst_n),
    .i_fault(fault), .i_ext_reset(ext), .i_addr(addr), .i_wdata(wdata),
    .i_write(wr), .i_read(rd), .o_rdata(rdata), .o_output_stop(stop),
    .o_alarm(alarm), .o_retry_reset(rr), .o_protect_clear(pclr),
    .o_retry_count_excess_fault(exc));
  initial forever #50 clk = ~clk;
  task test_done;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    comparisons = comparisons + 1;
    if (s !== e) begin
      $display("[ERR] %0s exp %0h got %0h", nm, e, s);
      err_total = err_total + 1;
    end
  endtask
  task wreg(input [7:0] a, input [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // One-cycle fault pulse, returns once the stop has been registered
  task flt(input [2:0] k);
    @(posedge clk);
    fault <= 8'h01 << k;
    @(posedge clk);
    fault <= 8'h00;
    @(posedge clk);
    #1;
  endtask
  task wait_rr(input integer lim, input must);
    n = 0;
    while (rr !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    if (must && rr !== 1'b1) begin
      err_total = err_total + 1;
      test_done;
    end
  endtask
  task ext_rst;
    @(posedge clk);
    ext <= 1'b1;
    repeat (8) @(posedge clk);
    ext <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  function exp_retry(input [2:0] gg, input [2:0] bb);
    reg [7:0] m;
    begin
      case (gg)
        3'h0: m = `FAR_MASK_G0;
        3'h1: m = `FAR_MASK_G1;
        3'h2: m = `FAR_MASK_G2;
        3'h3: m = `FAR_MASK_G3;
        3'h4: m = `FAR_MASK_G4;
        default: m = `FAR_MASK_G5;
      endcase
      exp_retry = m[bb];
    end
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`FAR_ADDR_GROUP, 32'h0);
    rchk(`FAR_ADDR_LIMIT, 32'h0);
    rchk(`FAR_ADDR_WAIT, 32'h0A);
    rchk(`FAR_ADDR_SUCCESS, 32'h0);
    flt(3'h0);
    chk("stop", 1, stop);
    wait_rr(30, 0);
    chk("noretry", 0, rr);
    chk("alarm", 1, alarm);
    ext_rst;
    chk("stop", 0, stop);
    $display("reset values and no-retry done");
    wreg(`FAR_ADDR_LIMIT, 32'h0A);
    wreg(`FAR_ADDR_WAIT, 32'h00);
    cnt = 0;
    for (i = 0; i < 16; i = i + 1) begin
      n = $random(seed);
      b = n[2:0];
      g = 3'(n[30:3] % 6);
      wreg(`FAR_ADDR_GROUP, {29'h0, g});
      flt(b);
      wait_rr(6, exp_retry(g, b));
      chk("retry", exp_retry(g, b), rr);
      if (rr === 1'b1)
        cnt = cnt + 1;
      else
        ext_rst;
    end
    rchk(`FAR_ADDR_SUCCESS, cnt);
    wreg(`FAR_ADDR_SUCCESS, 32'h05);
    rchk(`FAR_ADDR_SUCCESS, cnt);
    wreg(`FAR_ADDR_SUCCESS, 32'h00);
    rchk(`FAR_ADDR_SUCCESS, 32'h0);
    $display("group table done");
    wreg(`FAR_ADDR_GROUP, 32'h00);
    wreg(`FAR_ADDR_LIMIT, 32'h65);
    wreg(`FAR_ADDR_WAIT, 32'h02);
    flt(3'h0);
    chk("alarm", 1, alarm);
    wait_rr(20, 1);
    chk("wait", 1, n >= 6 && n <= 11);
    flt(3'h4);
    chk("excess", 1, exc);
    wait_rr(20, 0);
    chk("noretry", 0, rr);
    rchk(`FAR_ADDR_RECORD, 32'h0);
    rchk(`FAR_ADDR_SUCCESS, 32'h0);
    ext_rst;
    chk("excess", 0, exc);
    $display("alarm mode and excess done");
    wreg(`FAR_ADDR_LIMIT, 32'h01);
    flt(3'h6);
    chk("alarm", 0, alarm);
    wait_rr(20, 1);
    chk("pclr", 0, pclr);
    repeat (20) @(posedge clk);
    rchk(`FAR_ADDR_SUCCESS, 32'h0);
    repeat (20) @(posedge clk);
    rchk(`FAR_ADDR_SUCCESS, 32'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("pclr", 1, pclr);
    @(posedge clk);
    rst_n <= 1'b1;
    rchk(`FAR_ADDR_LIMIT, 32'h0);
    $display("success window and power-on reset done");
    test_done;
  end
endmodule
